// *** adcps_regs.svh ***
// Frame layout, field positions, reset values and counts of the power and sequencer control
`ifndef ADCPS_REGS_SVH
`define ADCPS_REGS_SVH

// ------------------------------------------------------------
// Serial frame
// ------------------------------------------------------------
`define ADCPS_COMMIT_EDGE 5'd14
`define ADCPS_LAST_EDGE 5'd16
`define ADCPS_BIT_WRITE 15
`define ADCPS_SEL_HI 14
`define ADCPS_SEL_LO 13
`define ADCPS_DATA_HI 12
`define ADCPS_DATA_LO 5

// ------------------------------------------------------------
// Register select codes
// ------------------------------------------------------------
`define ADCPS_SEL_CONTROL 2'b00
`define ADCPS_SEL_RANGE_LOW 2'b01
`define ADCPS_SEL_RANGE_HIGH 2'b10
`define ADCPS_SEL_SEQUENCE 2'b11

// ------------------------------------------------------------
// Control word fields
// ------------------------------------------------------------
`define ADCPS_PTR_HI 12
`define ADCPS_PTR_LO 10
`define ADCPS_MODE_HI 9
`define ADCPS_MODE_LO 8
`define ADCPS_PM_HI 7
`define ADCPS_PM_LO 6
`define ADCPS_CODING 5
`define ADCPS_REF 4
`define ADCPS_ORDER_A 3
`define ADCPS_ORDER_B 2

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define ADCPS_CTRL_RST 11'h000
`define ADCPS_RANGE_RST 8'h00
`define ADCPS_MASK_RST 8'h00

`endif

// *** adcps_pkg.sv ***
// Types shared by the power and sequencer control
package adcps_pkg;

	// Control register contents, kept across full shutdown
	typedef struct packed {
		logic [2:0] channel_pointer;
		logic [1:0] input_mode;
		logic power_select_hi;
		logic power_select_lo;
		logic coding;
		logic ref_internal;
		logic order_mode_bit_a;
		logic order_mode_bit_b;
	} adcps_ctrl_t;

	// Channel chosen for a conversion with the range it uses
	typedef struct packed {
		logic [2:0] channel;
		logic [1:0] range_code;
	} adcps_conv_t;

	// Range codes: 00 +-10 V, 01 +-5 V, 10 +-2.5 V, 11 0 to +10 V
	typedef enum logic [1:0] {
		ADCPS_RANGE_10V_BIP = 2'b00,
		ADCPS_RANGE_5V_BIP = 2'b01,
		ADCPS_RANGE_2V5_BIP = 2'b10,
		ADCPS_RANGE_10V_UNI = 2'b11
	} adcps_range_t;

	// Power states, Gray coded along normal, standby, shutdown, full off
	typedef enum logic [1:0] {
		ADCPS_PWR_NORMAL = 2'b00,
		ADCPS_PWR_STANDBY = 2'b01,
		ADCPS_PWR_SHUTDOWN = 2'b11,
		ADCPS_PWR_FULL_OFF = 2'b10
	} adcps_pwr_t;

	// Sequencer behaviour decoded from the two order bits
	typedef enum logic [1:0] {
		ADCPS_SEQ_IDLE = 2'b00,
		ADCPS_SEQ_MASK = 2'b01,
		ADCPS_SEQ_CONSEC = 2'b11
	} adcps_seq_t;

endpackage : adcps_pkg

// *** adcps_core.sv ***
// Serial frame capture, power sequencing, channel sequencer and range selection
`include "adcps_regs.svh"

// Contract
// R1 - Both power bits set: everything powered down, control register contents kept.
// R2 - Power bits 1,0: auto shutdown at 15th serial edge of updating frame.
// R3 - Power bits 0,1: auto standby at 15th edge, reference stays powered.
// R4 - Power bits 0,0: all circuitry powered continuously.
// R5 - Order bits equal: sequencer idle, next conversion uses channel pointer.
// R6 - Order bits 0,1: walk mask channels ascending from lowest, repeating.
// R7 - Order bits 1,0: walk channel 0 up to pointer channel, repeating.
// R8 - In sequencing, each channel uses its latest written range.
// R9 - Sequence mask is 8 write-only bits, one per channel, 1 includes.
// R10 - Mask frame: write, two selects, channels 0..7 from position 13, zeros. The code takes channel 0 from position 12.
// R11 - First range register written only on write=1, selects 0 then 1.
// R12 - First range register: two bits per channel 0..3 from position 13. The code takes channel 0 from positions 12 and 11.
// R13 - Second range register: same layout for channels 4..7.
// R14 - Selecting any channel applies that channel's held range automatically.
// R15 - Every channel defaults to range code 00 until written.
// R16 - Range codes: 00 +-10V, 01 +-5V, 10 +-2.5V, 11 0..+10V.
// R17 - Power bits sit at control positions 7 and 6.
// R18 - Order bits sit at control positions 3 and 2.
// R19 - Pointer picks next channel when idle, last channel when consecutive.
// R20 - Full shutdown begins at 15th edge after control update with 1,1.
// R21 - Range and mask writes apply from next selection, never mid-conversion.
// R22 - Empty mask in mask mode keeps previous channel selection.
module adcps_core (
	// System clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Serial link from the host
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic din,
	// Conversion selection
	output adcps_pkg::adcps_conv_t conv_sel,
	output logic conv_strobe,
	// Power state
	output logic core_power_on,
	output logic ref_power_on,
	// Control settings passed to the converter
	output logic [1:0] input_config,
	output logic coding_straight,
	output logic internal_ref_en
);

	// ------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------

	// R16 range lookup
	function automatic logic [1:0] adcps_range_of(input logic [7:0] lo, input logic [7:0] hi,
		input logic [2:0] ch);
		logic [7:0] bank;
		logic [2:0] slot;
		bank = ch[2] ? hi : lo;
		slot = 3'(3'd3 - {1'b0, ch[1:0]});
		return bank[{slot[1:0], 1'b0} +: 2];
	endfunction

	// Next enabled channel above cur with wrap, or lowest one on restart
	function automatic logic [2:0] adcps_next_in_mask(input logic [7:0] mask,
		input logic [2:0] cur, input logic restart);
		logic [2:0] pick;
		logic found;
		logic [2:0] cand;
		pick = cur;
		found = 1'b0;
		cand = 3'h0;
		for (int k = 1; k <= 8; k++) begin
			cand = restart ? 3'(k - 1) : 3'(cur + 3'(k));
			if (!found && mask[cand]) begin
				pick = cand;
				found = 1'b1;
			end
		end
		return pick;
	endfunction

	// R18 order bit decode
	function automatic adcps_pkg::adcps_seq_t adcps_seq_of(input logic a, input logic b);
		if (a == b)
			return adcps_pkg::ADCPS_SEQ_IDLE;
		else if (b)
			return adcps_pkg::ADCPS_SEQ_MASK;
		else
			return adcps_pkg::ADCPS_SEQ_CONSEC;
	endfunction

	// ------------------------------------------------------------
	// Link domain (serial clock)
	// ------------------------------------------------------------
	logic frame_rst_n;
	logic [4:0] edge_cnt;
	logic [13:0] shift;
	logic [15:0] frame_word;
	logic frame_tgl;

	// Chip select high clears the edge count even with the serial clock stopped
	assign frame_rst_n = rst_n & ~cs_n;

	// Rising edges counted within the frame
	always_ff @(posedge sclk or negedge frame_rst_n) begin
		if (!frame_rst_n)
			edge_cnt <= 5'h00;
		else if (edge_cnt != `ADCPS_LAST_EDGE)
			edge_cnt <= 5'(edge_cnt + 5'h01);
	end

	// Input bits shifted in, first bit ends up at the top
	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n)
			shift <= 14'h0000;
		else
			shift <= {shift[12:0], din};
	end

	// R20 commit on 15th edge; word held stable until the next frame's 15th edge
	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			frame_word <= 16'h0000;
			frame_tgl <= 1'b0;
		end else if (edge_cnt == `ADCPS_COMMIT_EDGE) begin
			frame_word <= {shift, din, 1'b0};
			frame_tgl <= ~frame_tgl;
		end
	end

	// ------------------------------------------------------------
	// Crossing into the system clock
	// ------------------------------------------------------------
	logic [1:0] tgl_sync;
	logic tgl_seen;
	logic [1:0] cs_sync;
	logic cs_prev;
	logic frame_done;
	logic frame_start;

	// Toggle and chip select each pass two flip-flops before use
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tgl_sync <= 2'b00;
			tgl_seen <= 1'b0;
			cs_sync <= 2'b11;
			cs_prev <= 1'b1;
		end else begin
			tgl_sync <= {tgl_sync[0], frame_tgl};
			tgl_seen <= tgl_sync[1];
			cs_sync <= {cs_sync[0], cs_n};
			cs_prev <= cs_sync[1];
		end
	end

	// Frame word is stable for a full frame after its toggle, so it is read directly
	assign frame_done = tgl_sync[1] ^ tgl_seen;
	assign frame_start = cs_prev & ~cs_sync[1];

	// ------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------
	logic [1:0] sel;
	logic wr_any;
	logic wr_ctrl;
	logic [7:0] data_field;
	logic [7:0] mask_field;
	adcps_pkg::adcps_ctrl_t ctrl;
	adcps_pkg::adcps_ctrl_t new_ctrl;
	logic [7:0] range_lo;
	logic [7:0] range_hi;
	logic [7:0] seq_mask;
	logic restart;
	adcps_pkg::adcps_pwr_t pwr;
	adcps_pkg::adcps_pwr_t next_pwr;
	logic [1:0] eff_pm;

	assign sel = {frame_word[`ADCPS_SEL_HI], frame_word[`ADCPS_SEL_LO]};
	assign wr_any = frame_done & frame_word[`ADCPS_BIT_WRITE];
	assign wr_ctrl = wr_any && sel == `ADCPS_SEL_CONTROL;
	assign data_field = frame_word[`ADCPS_DATA_HI:`ADCPS_DATA_LO];

	// R10 channel 0 arrives first, so the field is reversed into mask bit order
	always_comb begin
		for (int i = 0; i < 8; i++)
			mask_field[i] = data_field[7 - i];
	end

	// R17 R18 control fields at their frame positions
	assign new_ctrl = '{
		channel_pointer: frame_word[`ADCPS_PTR_HI:`ADCPS_PTR_LO],
		input_mode: frame_word[`ADCPS_MODE_HI:`ADCPS_MODE_LO],
		power_select_hi: frame_word[`ADCPS_PM_HI],
		power_select_lo: frame_word[`ADCPS_PM_LO],
		coding: frame_word[`ADCPS_CODING],
		ref_internal: frame_word[`ADCPS_REF],
		order_mode_bit_a: frame_word[`ADCPS_ORDER_A],
		order_mode_bit_b: frame_word[`ADCPS_ORDER_B]
	};

	// R1 control register survives every power state
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			ctrl <= `ADCPS_CTRL_RST;
		else if (wr_ctrl)
			ctrl <= new_ctrl;
	end

	// R11 R12 R13 R15 range registers, write-only, default code 00
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			range_lo <= `ADCPS_RANGE_RST;
			range_hi <= `ADCPS_RANGE_RST;
		end else if (wr_any && sel == `ADCPS_SEL_RANGE_LOW) begin
			range_lo <= data_field;
		end else if (wr_any && sel == `ADCPS_SEL_RANGE_HIGH) begin
			range_hi <= data_field;
		end
	end

	// R9 sequence mask, one bit per channel
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			seq_mask <= `ADCPS_MASK_RST;
		else if (wr_any && sel == `ADCPS_SEL_SEQUENCE)
			seq_mask <= mask_field;
	end

	// Control write restarts a walk from its first channel; set wins over the clear
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			restart <= 1'b1;
		else if (wr_ctrl)
			restart <= 1'b1;
		else if (frame_start && pwr != adcps_pkg::ADCPS_PWR_FULL_OFF)
			restart <= 1'b0;
	end

	// ------------------------------------------------------------
	// Power sequencing
	// ------------------------------------------------------------

	// Power bits as they stand after this frame's own write
	assign eff_pm = wr_ctrl ? {new_ctrl.power_select_hi, new_ctrl.power_select_lo}
		: {ctrl.power_select_hi, ctrl.power_select_lo};

	// Auto modes drop at the 15th edge and wake at the next chip select fall
	always_comb begin
		next_pwr = pwr;
		case (pwr)
			adcps_pkg::ADCPS_PWR_NORMAL,
			adcps_pkg::ADCPS_PWR_STANDBY,
			adcps_pkg::ADCPS_PWR_SHUTDOWN,
			adcps_pkg::ADCPS_PWR_FULL_OFF: begin
				if (frame_done) begin
					case (eff_pm)
						// R20 R1 full shutdown
						2'b11: next_pwr = adcps_pkg::ADCPS_PWR_FULL_OFF;
						// R2 auto shutdown
						2'b10: next_pwr = adcps_pkg::ADCPS_PWR_SHUTDOWN;
						// R3 auto standby
						2'b01: next_pwr = adcps_pkg::ADCPS_PWR_STANDBY;
						// R4 normal
						default: next_pwr = adcps_pkg::ADCPS_PWR_NORMAL;
					endcase
				end else if (frame_start && pwr != adcps_pkg::ADCPS_PWR_FULL_OFF) begin
					next_pwr = adcps_pkg::ADCPS_PWR_NORMAL;
				end
			end
			default: next_pwr = adcps_pkg::ADCPS_PWR_NORMAL;
		endcase
	end

	// Power state
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			pwr <= adcps_pkg::ADCPS_PWR_NORMAL;
		else
			pwr <= next_pwr;
	end

	// R3 R4 supply outputs follow the state in the same cycle; reference kept in standby
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			core_power_on <= 1'b1;
			ref_power_on <= 1'b1;
		end else begin
			core_power_on <= next_pwr == adcps_pkg::ADCPS_PWR_NORMAL;
			ref_power_on <= next_pwr == adcps_pkg::ADCPS_PWR_NORMAL ||
				next_pwr == adcps_pkg::ADCPS_PWR_STANDBY;
		end
	end

	// ------------------------------------------------------------
	// Channel sequencer
	// ------------------------------------------------------------
	adcps_pkg::adcps_seq_t seq_mode;
	logic [2:0] next_ch;

	assign seq_mode = adcps_seq_of(ctrl.order_mode_bit_a, ctrl.order_mode_bit_b);

	// Channel for the conversion that starts now
	always_comb begin
		next_ch = conv_sel.channel;
		case (seq_mode)
			// R5 R19 idle: pointer names the channel
			adcps_pkg::ADCPS_SEQ_IDLE: next_ch = ctrl.channel_pointer;
			// R6 R22 ascending through the mask; an empty mask keeps the last channel
			adcps_pkg::ADCPS_SEQ_MASK: next_ch = adcps_next_in_mask(seq_mask,
				conv_sel.channel, restart);
			// R7 R19 channel 0 up to the pointer, then back to 0
			adcps_pkg::ADCPS_SEQ_CONSEC: next_ch = (restart ||
				conv_sel.channel >= ctrl.channel_pointer) ? 3'h0
				: 3'(conv_sel.channel + 3'h1);
			default: next_ch = ctrl.channel_pointer;
		endcase
	end

	// R8 R14 R21 range latched with the channel, so later writes wait for the next one
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			conv_sel <= '0;
			conv_strobe <= 1'b0;
		end else begin
			conv_strobe <= 1'b0;
			if (frame_start && pwr != adcps_pkg::ADCPS_PWR_FULL_OFF) begin
				conv_sel.channel <= next_ch;
				conv_sel.range_code <= adcps_range_of(range_lo, range_hi, next_ch);
				conv_strobe <= 1'b1;
			end
		end
	end

	// Settings handed to the converter, from the retained control register
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			input_config <= 2'b00;
			coding_straight <= 1'b0;
			internal_ref_en <= 1'b0;
		end else begin
			input_config <= ctrl.input_mode;
			coding_straight <= ctrl.coding;
			internal_ref_en <= ctrl.ref_internal;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	logic sel_ok;
	assign sel_ok = frame_start && pwr != adcps_pkg::ADCPS_PWR_FULL_OFF;

	sequence s_auto_down;
		frame_done && eff_pm == 2'b10;
	endsequence

	sequence s_down_held;
		pwr == adcps_pkg::ADCPS_PWR_SHUTDOWN && !core_power_on && !ref_power_on;
	endsequence

	property p_auto_shutdown;
		@(posedge clock) disable iff (!rst_n)
		s_auto_down |=> s_down_held;
	endproperty
	a_auto_shutdown: assert property (p_auto_shutdown) // R2
		else $error("auto shutdown not entered after frame");

	property p_standby_ref;
		@(posedge clock) disable iff (!rst_n)
		frame_done && eff_pm == 2'b01 |=> !core_power_on && ref_power_on;
	endproperty
	a_standby_ref: assert property (p_standby_ref) // R3
		else $error("standby did not keep only the reference");

	property p_full_off_entry;
		@(posedge clock) disable iff (!rst_n)
		wr_ctrl && new_ctrl.power_select_hi && new_ctrl.power_select_lo
			|=> pwr == adcps_pkg::ADCPS_PWR_FULL_OFF && ctrl == $past(new_ctrl);
	endproperty
	a_full_off_entry: assert property (p_full_off_entry) // R20
		else $error("full shutdown not entered or control lost");

	property p_full_off_stays;
		@(posedge clock) disable iff (!rst_n)
		pwr == adcps_pkg::ADCPS_PWR_FULL_OFF && !wr_ctrl
			|=> pwr == adcps_pkg::ADCPS_PWR_FULL_OFF && $stable(ctrl) && !conv_strobe;
	endproperty
	a_full_off_stays: assert property (p_full_off_stays) // R1
		else $error("left full shutdown without a control write");

	property p_normal_on;
		@(posedge clock) disable iff (!rst_n)
		frame_done && eff_pm == 2'b00 |=> core_power_on && ref_power_on;
	endproperty
	a_normal_on: assert property (p_normal_on) // R4
		else $error("normal mode not fully powered");

	property p_idle_pointer;
		@(posedge clock) disable iff (!rst_n)
		sel_ok && seq_mode == adcps_pkg::ADCPS_SEQ_IDLE
			|=> conv_strobe && conv_sel.channel == $past(ctrl.channel_pointer);
	endproperty
	a_idle_pointer: assert property (p_idle_pointer) // R5
		else $error("idle sequencer did not use the pointer");

	property p_mask_member;
		@(posedge clock) disable iff (!rst_n)
		sel_ok && seq_mode == adcps_pkg::ADCPS_SEQ_MASK && seq_mask != 8'h00 && !wr_any
			|=> seq_mask[conv_sel.channel];
	endproperty
	a_mask_member: assert property (p_mask_member) // R6
		else $error("selected channel not in the mask");

	property p_mask_empty;
		@(posedge clock) disable iff (!rst_n)
		sel_ok && seq_mode == adcps_pkg::ADCPS_SEQ_MASK && seq_mask == 8'h00
			|=> $stable(conv_sel.channel);
	endproperty
	a_mask_empty: assert property (p_mask_empty) // R22
		else $error("empty mask changed the channel");

	property p_consec_wrap;
		@(posedge clock) disable iff (!rst_n)
		sel_ok && seq_mode == adcps_pkg::ADCPS_SEQ_CONSEC
			&& conv_sel.channel >= ctrl.channel_pointer |=> conv_sel.channel == 3'h0;
	endproperty
	a_consec_wrap: assert property (p_consec_wrap) // R7
		else $error("consecutive walk did not return to channel 0");

	property p_range_follows;
		@(posedge clock) disable iff (!rst_n)
		sel_ok |=> conv_sel.range_code ==
			adcps_range_of($past(range_lo), $past(range_hi), conv_sel.channel);
	endproperty
	a_range_follows: assert property (p_range_follows) // R14
		else $error("selected range does not match the channel's register");

endmodule // adcps_core

// *** adcps_host.sv ***
// Host serial master model that writes frames into the power and sequencer control
module adcps_host (
	// Serial link to the device
	output logic sclk,
	output logic cs_n,
	output logic din
);
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------
	// Idle levels
	// ------------------------------------------------------------
	// Serial clock stands still low between frames
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		din = 1'b1;
	end

	// ------------------------------------------------------------
	// Frame transfer
	// ------------------------------------------------------------
	// Sixteen edges at 12 ns, data changed on the falling edge
	task automatic send_frame(input logic [15:0] word);
		cs_n = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			din = word[i];
			#6;
			sclk = 1'b1;
			#6;
			sclk = 1'b0;
		end
		#6;
		cs_n = 1'b1;
		// Released line shows the inverse, so a stale bit is never read as valid
		din = ~word[0];
		// Long gap so the held word is taken before the next frame replaces it
		#500;
	endtask
endmodule : adcps_host

// *** testbench.sv ***
// Self-checking bench for the power and sequencer control
module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	logic clock;
	logic rst_n;
	logic sclk;
	logic cs_n;
	logic din;
	adcps_pkg::adcps_conv_t conv_sel;
	logic conv_strobe;
	logic core_power_on;
	logic ref_power_on;
	logic [1:0] input_config;
	logic coding_straight;
	logic internal_ref_en;
	adcps_pkg::adcps_conv_t seen_q[$];
	int miscompares = 0;
	int checks = 0;
	// Read-only frame with range-low select, must change nothing
	localparam logic [15:0] DUMMY = 16'h3fe0;

	// ------------------------------------------------------------
	// Clock, instances and capture
	// ------------------------------------------------------------
	initial clock = 1'b0;
	always #25 clock = ~clock;

	adcps_core i_adcps_core (
		.clock(clock),
		.rst_n(rst_n),
		.sclk(sclk),
		.cs_n(cs_n),
		.din(din),
		.conv_sel(conv_sel),
		.conv_strobe(conv_strobe),
		.core_power_on(core_power_on),
		.ref_power_on(ref_power_on),
		.input_config(input_config),
		.coding_straight(coding_straight),
		.internal_ref_en(internal_ref_en)
	);

	adcps_host i_adcps_host (
		.sclk(sclk),
		.cs_n(cs_n),
		.din(din)
	);

	// Every chosen channel is queued for the scenarios to judge
	always @(posedge clock) begin
		if (conv_strobe === 1'b1) begin
			seen_q.push_back(conv_sel);
		end
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic expect_sel(input logic [2:0] ch, input logic [1:0] rc);
		adcps_pkg::adcps_conv_t got;
		if (seen_q.size() == 0) begin
			check("strobe count", 8'h01, 8'h00);
		end else begin
			got = seen_q.pop_front();
			check("channel", {5'h00, ch}, {5'h00, got.channel});
			check("range code", {6'h00, rc}, {6'h00, got.range_code});
		end
	endtask

	// Configuration frame whose own selection is not of interest
	task automatic cfg(input logic [15:0] word);
		i_adcps_host.send_frame(word);
		seen_q.delete();
	endtask

	// Control word: pointer, input mode, power bits, order bits
	function automatic logic [15:0] ctrl(input logic [2:0] ptr, input logic [1:0] mode,
		input logic [1:0] pm, input logic [1:0] seq);
		return {3'b100, ptr, mode, pm, 2'b00, seq, 2'b00};
	endfunction

	task automatic check_power(input logic core, input logic ref_on);
		check("core power", {7'h00, core}, {7'h00, core_power_on});
		check("reference power", {7'h00, ref_on}, {7'h00, ref_power_on});
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		check_power(1'b1, 1'b1);
		check("input config", 8'h00, {6'h00, input_config});
		check("coding", 8'h00, {7'h00, coding_straight});
		$display("test reset done");
	endtask

	task automatic t_pointer();
		cfg(ctrl(3'd5, 2'b01, 2'b00, 2'b00) | 16'h0030);
		check("input config", 8'h01, {6'h00, input_config});
		check("coding", 8'h01, {7'h00, coding_straight});
		check("internal reference", 8'h01, {7'h00, internal_ref_en});
		i_adcps_host.send_frame(DUMMY);
		expect_sel(3'd5, 2'b00);
		cfg(ctrl(3'd2, 2'b00, 2'b00, 2'b11));
		i_adcps_host.send_frame(DUMMY);
		expect_sel(3'd2, 2'b00);
		$display("test pointer done");
	endtask

	task automatic t_consec();
		logic [1:0] rc [8];
		rc = '{2'b00, 2'b01, 2'b10, 2'b11, 2'b11, 2'b10, 2'b01, 2'b00};
		cfg({3'b101, 8'h1b, 5'h00});
		cfg({3'b110, 8'he4, 5'h00});
		cfg(ctrl(3'd7, 2'b00, 2'b00, 2'b10));
		// Nine frames so the walk wraps back to channel 0
		for (int i = 0; i < 9; i++) begin
			i_adcps_host.send_frame(DUMMY);
			expect_sel(i[2:0], rc[i % 8]);
		end
		$display("test consecutive done");
	endtask

	task automatic t_mask();
		logic [2:0] ch [7];
		logic [1:0] rc [7];
		ch = '{3'd1, 3'd4, 3'd6, 3'd1, 3'd4, 3'd6, 3'd1};
		rc = '{2'b01, 2'b11, 2'b01, 2'b01, 2'b11, 2'b01, 2'b11};
		cfg({3'b111, 8'h4a, 5'h00});
		cfg(ctrl(3'd0, 2'b00, 2'b00, 2'b01));
		// Fourth frame rewrites channel 1 range while the walk runs
		for (int i = 0; i < 7; i++) begin
			i_adcps_host.send_frame((i == 3) ? {3'b101, 8'h3b, 5'h00} : DUMMY);
			expect_sel(ch[i], rc[i]);
		end
		i_adcps_host.send_frame({3'b111, 8'h00, 5'h00});
		expect_sel(3'd4, 2'b11);
		i_adcps_host.send_frame(DUMMY);
		expect_sel(3'd4, 2'b11);
		$display("test mask done");
	endtask

	task automatic t_power();
		cfg(ctrl(3'd0, 2'b00, 2'b01, 2'b00));
		check_power(1'b0, 1'b1);
		cfg(ctrl(3'd0, 2'b00, 2'b10, 2'b00));
		check_power(1'b0, 1'b0);
		cfg(ctrl(3'd0, 2'b10, 2'b11, 2'b00));
		check_power(1'b0, 1'b0);
		i_adcps_host.send_frame(DUMMY);
		check("strobes while off", 8'h00, 8'(seen_q.size()));
		check("input config kept", 8'h02, {6'h00, input_config});
		check_power(1'b0, 1'b0);
		cfg(ctrl(3'd0, 2'b00, 2'b00, 2'b00));
		check_power(1'b1, 1'b1);
		$display("test power done");
	endtask

	// ------------------------------------------------------------
	// Verdict
	// ------------------------------------------------------------
	task automatic end_of_test();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	initial begin
		rst_n = 1'b0;
		repeat (5) @(posedge clock);
		rst_n <= 1'b1;
		repeat (2) @(posedge clock);
		// Outputs looked at away from the edge that updates them
		@(negedge clock);
		t_reset();
		t_pointer();
		t_consec();
		t_mask();
		t_power();
		end_of_test();
	end
endmodule : testbench
